// ==== hdl/chop_pkg.sv ====
// Purpose: shared constants and carrier types for the chopper and fault guard
// Assumes: 125 MHz mclk
// Notes: times in ns, cycle counts derived from the clock period
package chop_pkg;

    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NUM_PHASES = 2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned DEAD_NS = 500;
    localparam int unsigned DEAD_CYC = (DEAD_NS / CLK_PERIOD_NS) > 0 ?
        (DEAD_NS / CLK_PERIOD_NS) : 1;
    localparam int unsigned BLANK_NS = 1700;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OFF_LO_NS = 6000;
    localparam int unsigned OFF_MID_NS = 9000;
    localparam int unsigned OFF_HI_NS = 12000;
    localparam int unsigned OFF_LO_CYC = (OFF_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OFF_MID_CYC = (OFF_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OFF_HI_CYC = (OFF_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OPEN_WIN_NS = 2000;
    localparam int unsigned OPEN_WIN_CYC = (OPEN_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OPEN_CONFIRM = 3;
    localparam int unsigned CNT_W = 12;

    // ************************************************************
    // ratio thresholds (current ratio 0..255)
    // ************************************************************
    localparam logic [7:0] RATIO_MID = 8'h55;
    localparam logic [7:0] RATIO_HI = 8'haa;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic trip;   // sense_voltage reached trip_voltage
        logic short_hit; // sense_voltage above short_threshold
        logic positive;  // sense_voltage above zero
    } sense_t;

    typedef struct packed {
        logic on_side;
        logic off_side;
    } gate_t;

endpackage

// ==== hdl/phase_chopper.sv ====
// Purpose: per-phase fixed off-time chopper with dead time, off window shown for open watch
// Assumes: comparator inputs already synchronised
// Notes: gates forced low while kill is high
`timescale 1ns/1ps
`default_nettype none
module phase_chopper
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic kill,
    input wire logic [7:0] ratio,
    input wire chop_pkg::sense_t sense,
    output chop_pkg::gate_t gate,
    output logic in_off,
    output logic off_last
);
    import chop_pkg::*;

    typedef enum logic [2:0] {ST_DEAD_ON, ST_ON, ST_DEAD_OFF, ST_OFF} st_t;
    st_t st_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] off_len;

    always_comb
    begin
        if (ratio >= RATIO_HI)
            off_len = CNT_W'(OFF_HI_CYC);
        else if (ratio >= RATIO_MID)
            off_len = CNT_W'(OFF_MID_CYC);
        else
            off_len = CNT_W'(OFF_LO_CYC);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= ST_DEAD_ON;
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
            case (st_q)
                ST_DEAD_ON:
                    if (cnt_q >= CNT_W'(DEAD_CYC - 1))
                    begin
                        st_q <= ST_ON;
                        cnt_q <= '0;
                    end
                ST_ON:
                    // comparator masked during blanking
                    if (cnt_q >= CNT_W'(BLANK_CYC - 1) && sense.trip)
                    begin
                        st_q <= ST_DEAD_OFF;
                        cnt_q <= '0;
                    end
                ST_DEAD_OFF:
                    if (cnt_q >= CNT_W'(DEAD_CYC - 1))
                    begin
                        st_q <= ST_OFF;
                        cnt_q <= '0;
                    end
                ST_OFF:
                    // time fixed by the clock, not by coil current
                    if (cnt_q >= off_len - 1'b1)
                    begin
                        st_q <= ST_DEAD_ON;
                        cnt_q <= '0;
                    end
                default:
                begin
                    st_q <= ST_DEAD_ON;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            gate <= '0;
        else if (kill)
            gate <= '0;
        else
        begin
            gate.on_side <= (st_q == ST_ON);
            gate.off_side <= (st_q == ST_OFF);
        end
    end

    // ************************************************************
    // off window for the open-coil watch
    // ************************************************************
    assign in_off = (st_q == ST_OFF);
    assign off_last = (st_q == ST_OFF) && (cnt_q >= off_len - 1'b1);

endmodule // phase_chopper
`default_nettype wire

// ==== hdl/stepper_pwm_offtime_fault_guard.sv ====
// Purpose: chopper timing and latched fault shutdown for a two-phase unipolar driver
// Assumes: rstn is the power-on reset of the logic supply
// Notes: comparator results arrive asynchronously and are synchronised here
//
// Functional notes
// - each phase holds its off period for a fixed clock-counted time after chopping.
// - the off period is one of three lengths picked by the step current ratio.
// - during the off period the off-side transistor is on for synchronous rectification.
// - a dead interval of about 0.5 us separates one transistor off and its partner on.
// - all outputs go off as soon as sense_voltage exceeds short_threshold.
// - after a short the outputs stay off until logic_supply is cycled.
// - a positive sense_voltage in the off period flags a possible open coil.
// - an open coil is confirmed after three consecutive flagged off periods, else restart.
// - the accumulated breakdown time must also exceed a fixed window before shutdown.
// - all outputs go off when the control_die thermal detector trips.
// - the on period ends when sense_voltage reaches trip_voltage.
// - the comparator is ignored for a blanking time after each turn-on.
// - thermal shutdown clears only by cycling logic_supply.
`timescale 1ns/1ps
`default_nettype none
module stepper_pwm_offtime_fault_guard
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] ratio_a,
    input wire logic [7:0] ratio_b,
    input wire chop_pkg::sense_t sense_a,
    input wire chop_pkg::sense_t sense_b,
    input wire logic thermal_trip,
    output chop_pkg::gate_t gate_a,
    output chop_pkg::gate_t gate_b,
    output logic fault_latched,
    output logic [2:0] fault_cause
);
    import chop_pkg::*;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    sense_t sa_m_q, sa_q, sb_m_q, sb_q;
    logic th_m_q, th_q;
    gate_t ga, gb;
    logic open_a, open_b;
    wire logic [NUM_PHASES-1:0] in_off;
    wire logic [NUM_PHASES-1:0] off_last;
    wire logic [NUM_PHASES-1:0] open_hit;
    logic [NUM_PHASES-1:0] pos_now;
    logic short_now;
    logic dis_q;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sa_m_q <= '0;
            sa_q <= '0;
            sb_m_q <= '0;
            sb_q <= '0;
            th_m_q <= 1'b0;
            th_q <= 1'b0;
        end
        else
        begin
            sa_m_q <= sense_a;
            sa_q <= sa_m_q;
            sb_m_q <= sense_b;
            sb_q <= sb_m_q;
            th_m_q <= thermal_trip;
            th_q <= th_m_q;
        end
    end

    // short acts straight on the gate outputs, no wait for the latch
    assign short_now = sa_q.short_hit | sb_q.short_hit;

    // ************************************************************
    // latched disable
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            dis_q <= 1'b0;
            fault_cause <= '0;
        end
        else
        begin
            // no clear path besides reset: only supply cycling releases it
            if (short_now || open_a || open_b || th_q)
                dis_q <= 1'b1;
            fault_cause <= fault_cause | {th_q, open_a | open_b, short_now};
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            fault_latched <= 1'b0;
        else
            fault_latched <= dis_q | short_now | th_q | open_a | open_b;
    end

    // ************************************************************
    // open coil watch, one per phase
    // ************************************************************
    assign pos_now = {sb_q.positive, sa_q.positive};
    assign open_a = open_hit[0];
    assign open_b = open_hit[1];

    for (genvar p = 0; p < NUM_PHASES; p++)
    begin : g_open
        logic off_open_q;
        logic [1:0] open_run_q;
        logic [CNT_W-1:0] brk_q;
        logic open_q;

        // positive sense where recirculation should pull it negative
        always_ff @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
            begin
                off_open_q <= 1'b0;
            end
            else if (off_last[p])
            begin
                off_open_q <= 1'b0;
            end
            else if (in_off[p] && pos_now[p])
            begin
                off_open_q <= 1'b1;
            end
        end

        // consecutive flagged off periods; a clean one starts over
        always_ff @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
            begin
                open_run_q <= '0;
            end
            else if (off_last[p])
            begin
                if (!(off_open_q || pos_now[p]))
                begin
                    open_run_q <= '0;
                end
                else if (open_run_q != 2'(OPEN_CONFIRM))
                begin
                    open_run_q <= open_run_q + 2'h1;
                end
            end
        end

        // breakdown time, summed over the flagged run only
        always_ff @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
            begin
                brk_q <= '0;
            end
            else if (off_last[p] && !(off_open_q || pos_now[p]))
            begin
                brk_q <= '0;
            end
            else if (in_off[p] && pos_now[p] && brk_q != '1)
            begin
                brk_q <= brk_q + 1'b1;
            end
        end

        // short surges fill the window only after many consecutive flagged off periods
        always_ff @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
            begin
                open_q <= 1'b0;
            end
            else
            begin
                open_q <= (open_run_q == 2'(OPEN_CONFIRM))
                    && (brk_q > CNT_W'(OPEN_WIN_CYC));
            end
        end

        assign open_hit[p] = open_q;
    end

    phase_chopper u_phase_a
    (
        .mclk(mclk),
        .rstn(rstn),
        .kill(dis_q | short_now | th_q),
        .ratio(ratio_a),
        .sense(sa_q),
        .gate(ga),
        .in_off(in_off[0]),
        .off_last(off_last[0])
    );

    phase_chopper u_phase_b
    (
        .mclk(mclk),
        .rstn(rstn),
        .kill(dis_q | short_now | th_q),
        .ratio(ratio_b),
        .sense(sb_q),
        .gate(gb),
        .in_off(in_off[1]),
        .off_last(off_last[1])
    );

    // ************************************************************
    // output stage
    // ************************************************************
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            gate_a <= '0;
            gate_b <= '0;
        end
        else if (dis_q || short_now || th_q || open_a || open_b)
        begin
            gate_a <= '0;
            gate_b <= '0;
        end
        else
        begin
            gate_a <= ga;
            gate_b <= gb;
        end
    end

endmodule // stepper_pwm_offtime_fault_guard
`default_nettype wire

// ==== testbench/coil_model.sv ====
// Purpose: one winding and its sense resistor
// Assumes: gate high = transistor on
// Notes: open_mode 0 normal, 1 open coil, 2 surge only
`timescale 1ns/1ps
`default_nettype none
module coil_model
#(parameter int RISE = 40)
(
    input wire logic mclk,
    input wire chop_pkg::gate_t gate,
    input wire logic [1:0] open_mode,
    input wire logic short_coil,
    output chop_pkg::sense_t sense
);
    import chop_pkg::*;
    logic [11:0] cur_q = 12'h000;
    logic [11:0] off_q = 12'h000;
    always_ff @(posedge mclk)
    begin
        cur_q <= gate.on_side ? cur_q + 12'h001 : 12'h000;
        off_q <= gate.off_side ? off_q + 12'h001 : 12'h000;
    end
    // surge mode: positive only briefly, so breakdown time stays short
    assign sense.positive = gate.off_side && (open_mode == 2'h1 ||
        (open_mode == 2'h2 && off_q < 12'h014));
    assign sense.trip = cur_q >= 12'(RISE);
    assign sense.short_hit = short_coil;
endmodule // coil_model
`default_nettype wire

// ==== testbench/guard_properties.sv ====
// Purpose: port timing and latch checks
// Assumes: gates high = on
// Notes: switching timing checks on phase a only, overlap checked on both phases
`timescale 1ns/1ps
`default_nettype none
module guard_properties
(
    input wire logic mclk,
    input wire logic rstn,
    input wire chop_pkg::sense_t sense_a,
    input wire chop_pkg::sense_t sense_b,
    input wire logic thermal_trip,
    input wire chop_pkg::gate_t gate_a,
    input wire chop_pkg::gate_t gate_b,
    input wire logic fault_latched,
    input wire logic [2:0] fault_cause
);
    import chop_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ********
    // sequences
    // ********
    sequence both_low;
        (!gate_a.on_side && !gate_a.off_side) [*8];
    endsequence
    sequence short_seen;
        sense_a.short_hit || sense_b.short_hit;
    endsequence
    AST_NO_OVERLAP: assert property (
        !(gate_a.on_side && gate_a.off_side) && !(gate_b.on_side && gate_b.off_side))
        else $error("both switches of a phase on");
    AST_DEAD_GAP: assert property ($fell(gate_a.on_side) |=> both_low)
        else $error("no dead gap after on");
    AST_DEAD_LEN: assert property (
        $rose(gate_a.off_side) |-> !$past(gate_a.on_side, 60))
        else $error("dead gap too short");
    AST_ON_MIN: assert property (
        $fell(gate_a.on_side) && !fault_latched |-> $past(gate_a.on_side, 210))
        else $error("on period shorter than blanking");
    AST_OFF_MIN: assert property (
        $fell(gate_a.off_side) && !fault_latched |-> $past(gate_a.off_side, 740))
        else $error("off period too short");
    AST_SHORT: assert property (
        short_seen |-> ##[1:4] (fault_latched && fault_cause[0]))
        else $error("short not latched in time");
    AST_THERMAL: assert property (
        thermal_trip |-> ##[1:4] (fault_latched && fault_cause[2]))
        else $error("thermal not latched in time");
    AST_GATES_OFF: assert property (
        fault_latched |-> (gate_a == '0 && gate_b == '0))
        else $error("gate on while disabled");
    AST_STICKY: assert property (
        fault_latched |=> fault_latched && ((fault_cause & $past(fault_cause)) == $past(fault_cause)))
        else $error("latched fault cleared");
endmodule // guard_properties
bind stepper_pwm_offtime_fault_guard guard_properties guard_properties_inst (
    .mclk(mclk), .rstn(rstn), .sense_a(sense_a), .sense_b(sense_b),
    .thermal_trip(thermal_trip), .gate_a(gate_a), .gate_b(gate_b),
    .fault_latched(fault_latched), .fault_cause(fault_cause));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the chopper and fault guard
// Assumes: 125 MHz mclk
// Notes: every test starts from a fresh power-on reset
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import chop_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] ratio_a = 8'h00;
    logic [7:0] ratio_b = 8'hff;
    logic thermal_trip = 1'b0;
    logic [1:0] open_a = 2'h0;
    logic short_b = 1'b0;
    sense_t sense_a;
    sense_t sense_b;
    gate_t gate_a;
    gate_t gate_b;
    logic fault_latched;
    logic [2:0] fault_cause;
    int error_cnt = 0;
    int compares = 0;
    always #4 mclk = ~mclk;
    stepper_pwm_offtime_fault_guard stepper_pwm_offtime_fault_guard_inst (.mclk(mclk),
        .rstn(rstn), .ratio_a(ratio_a), .ratio_b(ratio_b), .sense_a(sense_a),
        .sense_b(sense_b), .thermal_trip(thermal_trip), .gate_a(gate_a), .gate_b(gate_b),
        .fault_latched(fault_latched), .fault_cause(fault_cause));
    coil_model coil_model_inst (.mclk(mclk), .gate(gate_a), .open_mode(open_a),
        .short_coil(1'b0), .sense(sense_a));
    coil_model coil_model_b_inst (.mclk(mclk), .gate(gate_b), .open_mode(2'h0),
        .short_coil(short_b), .sense(sense_b));
    // ********
    // helpers
    // ********
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc();
        @(posedge mclk);
        #1;
    endtask
    // counts cycles while one gate bit of phase a stays at lvl
    task automatic meas(input int idx, input logic lvl, output int n);
        n = 0;
        while (gate_a[idx] === lvl && n < 4000)
        begin
            cyc();
            n++;
        end
    endtask
    task automatic do_reset();
        rstn <= 1'b0;
        open_a <= 2'h0;
        repeat (12) @(posedge mclk);
        chk("outputs in reset", 0, {gate_a, gate_b, fault_latched, fault_cause});
        rstn <= 1'b1;
    endtask
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ********
    // tests
    // ********
    task automatic t_offtime();
        int n;
        logic [7:0] r [4] = '{8'h54, 8'h55, 8'ha9, 8'haa};
        int e [4] = '{OFF_LO_CYC, OFF_MID_CYC, OFF_MID_CYC, OFF_HI_CYC};
        for (int i = 0; i < 4; i++)
        begin
            do_reset();
            ratio_a <= r[i];
            meas(1, 1'b0, n);
            meas(1, 1'b1, n);
            chk("on time", 1, n >= BLANK_CYC && n <= BLANK_CYC + 4);
            meas(0, 1'b0, n);
            chk("dead gap", DEAD_CYC, n);
            chk("off gates", 2'b01, gate_a);
            meas(0, 1'b1, n);
            chk("off time", e[i], n);
        end
        $display("off time test done");
    endtask
    task automatic t_open(input logic [1:0] mode, input logic [2:0] exp);
        int n;
        do_reset();
        open_a <= mode;
        for (int k = 0; k < 2; k++)
        begin
            meas(0, 1'b0, n);
            meas(0, 1'b1, n);
        end
        chk("early open latch", 0, fault_latched);
        meas(0, 1'b0, n);
        meas(0, 1'b1, n);
        repeat (8) cyc();
        chk("open cause", exp, fault_cause);
        $display("open test done mode %0d", mode);
    endtask
    // a clean off period between flagged ones must start the count over
    task automatic t_restart();
        int n;
        do_reset();
        open_a <= 2'h1;
        for (int k = 0; k < 5; k++)
        begin
            meas(0, 1'b0, n);
            meas(0, 1'b1, n);
            @(posedge mclk);
            open_a <= (k == 1) ? 2'h0 : 2'h1;
        end
        repeat (8) cyc();
        chk("open after restart", 0, fault_latched);
        $display("restart test done");
    endtask
    task automatic t_latch(input logic heat);
        logic [7:0] exp;
        exp = heat ? 8'h0c : 8'h09;
        do_reset();
        repeat (300) @(posedge mclk);
        thermal_trip <= heat;
        short_b <= !heat;
        @(posedge mclk);
        thermal_trip <= 1'b0;
        short_b <= 1'b0;
        repeat (4) cyc();
        chk("latch at once", exp, {gate_a, gate_b, fault_latched, fault_cause});
        repeat (2000) cyc();
        chk("latch holds", exp, {gate_a, gate_b, fault_latched, fault_cause});
        $display("latch test done heat %0d", heat);
    endtask
    initial
    begin
        t_offtime();
        t_open(2'h1, 3'b010);
        t_open(2'h2, 3'b000);
        t_restart();
        t_latch(1'b0);
        t_latch(1'b1);
        test_done();
    end
    // hang guard, well past the roughly 31000 cycles the tests need
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        $display("BAD watchdog expected done seen hang");
        test_done();
    end
endmodule // tb_top
`default_nettype wire
